// ---- src/ulpisr_pkg.sv ----
// What this block does
// - link ends a stream with one-cycle stp
// - stp marks previous byte as the last
// - chip reset low suspends, high runs normally
// - chip reset is asynchronous, synchronised inside
// - long chip reset restores defaults and machines
// - clock-in mode runs on link reference clock
// - clock-out mode uses a fixed divider, frequency straps only latched
// - pins float while chip reset held low
// - data bit 7 is the msb
// - dir high takes bus, low listens
// - nxt marks the accepted byte
// - clock-out mode drives ulpi clock, synchronous outputs
package ulpisr_pkg;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned ULPI_MHZ = 60;
    localparam int unsigned RESET_MIN_NS = 1000;
    localparam int unsigned RESET_HOLD_CYC =
        (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned REF_SEL_W = 2;
    localparam int unsigned ACC_W = 8;
    localparam logic [7:0] IDLE_BYTE = 8'h00;
    localparam logic [ACC_W:0] ACC_STEP = 9'(ULPI_MHZ);
    localparam logic [ACC_W:0] ACC_MOD = 9'(CLK_MHZ);

    // fractional divider: tick in msb, next accumulator below it
    function automatic logic [ACC_W:0] acc_step(
        input logic [ACC_W-1:0] acc
    );
        logic [ACC_W:0] sum;
        sum = {1'b0, acc} + ACC_STEP;
        if (sum >= ACC_MOD)
        begin
            acc_step = {1'b1, ACC_W'(sum - ACC_MOD)};
        end
        else
        begin
            acc_step = {1'b0, sum[ACC_W-1:0]};
        end
    endfunction : acc_step
endpackage : ulpisr_pkg

// ---- src/ulpisr_if.sv ----
`timescale 1ns/10ps
interface ulpisr_if;
    logic ulpi_clock_output;
    logic ulpi_clock_output_oe;
    logic link_ref_clk;
    logic link_ref_clk_oe;
    logic osc_clk;
    logic reference_clock_in;
    logic dir;
    logic dir_oe;
    logic nxt;
    logic nxt_oe;
    logic stp;
    logic [7:0] phy_data;
    logic phy_data_oe;
    logic [7:0] link_data;
    logic link_data_oe;
    logic [7:0] data;

    // wire resolution: enabled driver wins, undriven bus reads as zero
    assign data = phy_data_oe ? phy_data :
        (link_data_oe ? link_data : 8'h00);
    assign reference_clock_in = link_ref_clk_oe ? link_ref_clk : osc_clk;

    modport phy (
        output ulpi_clock_output,
        output ulpi_clock_output_oe,
        input reference_clock_in,
        output dir,
        output dir_oe,
        output nxt,
        output nxt_oe,
        input stp,
        output phy_data,
        output phy_data_oe,
        input data
    );
    modport link (
        input ulpi_clock_output,
        output link_ref_clk,
        output link_ref_clk_oe,
        input dir,
        input nxt,
        output stp,
        output link_data,
        output link_data_oe,
        input data
    );
endinterface : ulpisr_if

// ---- src/ulpisr_link.sv ----
`timescale 1ns/10ps
module ulpisr_link (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clock_in_mode_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    input wire logic tx_last_i,
    output logic tx_ready_o,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic rx_last_o,
    ulpisr_if.link bus
);
    typedef enum logic [1:0] {LNK_IDLE, LNK_TX, LNK_STOP, LNK_RX}
        ulpisr_lnk_state_t;
    ulpisr_lnk_state_t state_q;
    logic [ulpisr_pkg::ACC_W-1:0] acc_q;
    logic [ulpisr_pkg::ACC_W:0] acc_nx;
    logic ref_q;
    logic mode_q;
    logic clk_prev_q;
    logic act;
    logic last_q;
    logic [7:0] data_q;
    logic oe_q;
    logic stp_q;
    logic [7:0] pend_q;
    logic pend_v_q;
    logic tx_ready_q;
    logic [7:0] rx_data_q;
    logic rx_valid_q;
    logic rx_last_q;

    assign acc_nx = ulpisr_pkg::acc_step(acc_q);
    // both ends act on the edge that ends the one-cycle clock pulse
    assign act = mode_q ? ref_q
        : (bus.ulpi_clock_output & ~clk_prev_q);

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            mode_q <= 1'b0;
            acc_q <= '0;
            ref_q <= 1'b0;
            clk_prev_q <= 1'b0;
        end
        else
        begin
            mode_q <= clock_in_mode_i;
            clk_prev_q <= bus.ulpi_clock_output;
            acc_q <= acc_nx[ulpisr_pkg::ACC_W-1:0];
            ref_q <= mode_q & acc_nx[ulpisr_pkg::ACC_W];
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_q <= LNK_IDLE;
            data_q <= ulpisr_pkg::IDLE_BYTE;
            oe_q <= 1'b0;
            stp_q <= 1'b0;
            last_q <= 1'b0;
            pend_q <= ulpisr_pkg::IDLE_BYTE;
            pend_v_q <= 1'b0;
            tx_ready_q <= 1'b0;
            rx_data_q <= ulpisr_pkg::IDLE_BYTE;
            rx_valid_q <= 1'b0;
            rx_last_q <= 1'b0;
        end
        else
        begin
            tx_ready_q <= 1'b0;
            rx_valid_q <= 1'b0;
            if (act)
            begin
                case (state_q)
                    LNK_IDLE:
                    begin
                        if (bus.dir)
                        begin
                            state_q <= LNK_RX;
                        end
                        else if (tx_valid_i)
                        begin
                            data_q <= tx_data_i;
                            last_q <= tx_last_i;
                            oe_q <= 1'b1;
                            tx_ready_q <= 1'b1;
                            state_q <= LNK_TX;
                        end
                    end
                    LNK_TX:
                    begin
                        if (bus.dir)
                        begin
                            oe_q <= 1'b0;
                            data_q <= ulpisr_pkg::IDLE_BYTE;
                            state_q <= LNK_RX;
                        end
                        else if (bus.nxt)
                        begin
                            if (!last_q && tx_valid_i)
                            begin
                                data_q <= tx_data_i;
                                last_q <= tx_last_i;
                                tx_ready_q <= 1'b1;
                            end
                            else
                            begin
                                // an underrun also ends the stream here
                                data_q <= ulpisr_pkg::IDLE_BYTE;
                                stp_q <= 1'b1;
                                state_q <= LNK_STOP;
                            end
                        end
                    end
                    LNK_STOP:
                    begin
                        stp_q <= 1'b0;
                        oe_q <= 1'b0;
                        state_q <= bus.dir ? LNK_RX : LNK_IDLE;
                    end
                    LNK_RX:
                    begin
                        oe_q <= 1'b0;
                        if (!bus.dir)
                        begin
                            rx_valid_q <= pend_v_q;
                            rx_last_q <= 1'b1;
                            rx_data_q <= pend_q;
                            pend_v_q <= 1'b0;
                            state_q <= LNK_IDLE;
                        end
                        else if (bus.nxt)
                        begin
                            rx_valid_q <= pend_v_q;
                            rx_last_q <= 1'b0;
                            rx_data_q <= pend_q;
                            pend_q <= bus.data;
                            pend_v_q <= 1'b1;
                        end
                    end
                    default:
                    begin
                        state_q <= LNK_IDLE;
                    end
                endcase
            end
        end
    end

    assign bus.link_ref_clk = ref_q;
    assign bus.link_ref_clk_oe = mode_q;
    assign bus.stp = stp_q;
    assign bus.link_data = data_q;
    assign bus.link_data_oe = oe_q;
    assign tx_ready_o = tx_ready_q;
    assign rx_data_o = rx_data_q;
    assign rx_valid_o = rx_valid_q;
    assign rx_last_o = rx_last_q;
endmodule : ulpisr_link

// ---- src/ulpisr_phy.sv ----
`timescale 1ns/10ps
module ulpisr_phy #(
    parameter int unsigned RESET_HOLD_CYC = ulpisr_pkg::RESET_HOLD_CYC
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic chip_reset_n_i,
    input wire logic interface_supply_i,
    input wire logic clock_in_mode_i,
    input wire logic [1:0] ref_sel_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    input wire logic tx_last_i,
    output logic tx_ready_o,
    input wire logic rx_ready_i,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic rx_last_o,
    output logic suspended_o,
    output logic [1:0] ref_sel_o,
    output logic clock_in_mode_o,
    ulpisr_if.phy bus
);
    typedef enum logic [1:0] {PHY_IDLE, PHY_TURN, PHY_SEND, PHY_RECV}
        ulpisr_phy_state_t;
    ulpisr_phy_state_t state_q;
    logic rst_meta_q;
    logic rst_sync_q;
    logic rst_prev_q;
    logic [15:0] hold_cnt_q;
    logic soft_rst;
    logic cfg_valid_q;
    logic mode_q;
    logic [1:0] ref_sel_q;
    logic [ulpisr_pkg::ACC_W-1:0] acc_q;
    logic [ulpisr_pkg::ACC_W:0] acc_nx;
    logic clk_out_q;
    logic clk_oe_q;
    logic ref_prev_q;
    logic pins_on_q;
    logic suspended_q;
    logic act;
    logic dir_q;
    logic nxt_q;
    logic [7:0] data_q;
    logic data_oe_q;
    logic sent_last_q;
    logic [7:0] pend_q;
    logic pend_v_q;
    logic tx_ready_q;
    logic [7:0] rx_data_q;
    logic rx_valid_q;
    logic rx_last_q;

    // two stages before anything looks at the chip reset level
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= chip_reset_n_i;
            rst_sync_q <= rst_meta_q;
        end
    end

    // a release only counts as a full reset after a long enough low
    assign soft_rst = rst_sync_q & ~rst_prev_q
        & (hold_cnt_q >= 16'(RESET_HOLD_CYC));

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_prev_q <= 1'b0;
            hold_cnt_q <= '0;
        end
        else
        begin
            rst_prev_q <= rst_sync_q;
            if (rst_sync_q)
            begin
                if (rst_prev_q)
                begin
                    hold_cnt_q <= '0;
                end
            end
            else if (hold_cnt_q < 16'(RESET_HOLD_CYC))
            begin
                hold_cnt_q <= hold_cnt_q + 16'h0001;
            end
        end
    end

    // straps are only re-read by a full reset, a short glitch keeps them
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cfg_valid_q <= 1'b0;
            mode_q <= 1'b0;
            ref_sel_q <= '0;
        end
        else if (!cfg_valid_q || soft_rst)
        begin
            cfg_valid_q <= 1'b1;
            mode_q <= clock_in_mode_i;
            ref_sel_q <= ref_sel_i;
        end
    end

    assign acc_nx = ulpisr_pkg::acc_step(acc_q);

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            acc_q <= '0;
            clk_out_q <= 1'b0;
            clk_oe_q <= 1'b0;
            ref_prev_q <= 1'b0;
            pins_on_q <= 1'b0;
            suspended_q <= 1'b1;
        end
        else
        begin
            ref_prev_q <= bus.reference_clock_in;
            pins_on_q <= rst_sync_q & interface_supply_i;
            suspended_q <= ~(rst_sync_q & interface_supply_i);
            clk_oe_q <= rst_sync_q & interface_supply_i & ~mode_q;
            if (rst_sync_q && !mode_q)
            begin
                acc_q <= acc_nx[ulpisr_pkg::ACC_W-1:0];
                clk_out_q <= acc_nx[ulpisr_pkg::ACC_W];
            end
            else
            begin
                acc_q <= '0;
                clk_out_q <= 1'b0;
            end
        end
    end

    // one action per ulpi clock, on whichever source the mode selects
    assign act = mode_q
        ? (bus.reference_clock_in & ~ref_prev_q)
        : clk_out_q;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_q <= PHY_IDLE;
            dir_q <= 1'b0;
            nxt_q <= 1'b0;
            data_q <= ulpisr_pkg::IDLE_BYTE;
            data_oe_q <= 1'b0;
            sent_last_q <= 1'b0;
            pend_q <= ulpisr_pkg::IDLE_BYTE;
            pend_v_q <= 1'b0;
            tx_ready_q <= 1'b0;
            rx_data_q <= ulpisr_pkg::IDLE_BYTE;
            rx_valid_q <= 1'b0;
            rx_last_q <= 1'b0;
        end
        else if (!rst_sync_q || soft_rst)
        begin
            state_q <= PHY_IDLE;
            dir_q <= 1'b0;
            nxt_q <= 1'b0;
            data_q <= ulpisr_pkg::IDLE_BYTE;
            data_oe_q <= 1'b0;
            sent_last_q <= 1'b0;
            pend_v_q <= 1'b0;
            tx_ready_q <= 1'b0;
            rx_valid_q <= 1'b0;
        end
        else
        begin
            tx_ready_q <= 1'b0;
            rx_valid_q <= 1'b0;
            if (act)
            begin
                case (state_q)
                    PHY_IDLE:
                    begin
                        if (tx_valid_i)
                        begin
                            dir_q <= 1'b1;
                            state_q <= PHY_TURN;
                        end
                        else if (bus.data != ulpisr_pkg::IDLE_BYTE)
                        begin
                            nxt_q <= rx_ready_i;
                            state_q <= PHY_RECV;
                        end
                    end
                    PHY_TURN, PHY_SEND:
                    begin
                        if (state_q == PHY_SEND && sent_last_q)
                        begin
                            dir_q <= 1'b0;
                            data_oe_q <= 1'b0;
                            nxt_q <= 1'b0;
                            sent_last_q <= 1'b0;
                            data_q <= ulpisr_pkg::IDLE_BYTE;
                            state_q <= PHY_IDLE;
                        end
                        else
                        begin
                            // idle status byte with nxt low on underrun
                            data_oe_q <= 1'b1;
                            state_q <= PHY_SEND;
                            nxt_q <= tx_valid_i;
                            tx_ready_q <= tx_valid_i;
                            sent_last_q <= tx_valid_i & tx_last_i;
                            data_q <= tx_valid_i ? tx_data_i
                                : ulpisr_pkg::IDLE_BYTE;
                        end
                    end
                    PHY_RECV:
                    begin
                        if (bus.stp)
                        begin
                            rx_valid_q <= pend_v_q;
                            rx_last_q <= 1'b1;
                            rx_data_q <= pend_q;
                            pend_v_q <= 1'b0;
                            nxt_q <= 1'b0;
                            state_q <= PHY_IDLE;
                        end
                        else
                        begin
                            if (nxt_q)
                            begin
                                rx_valid_q <= pend_v_q;
                                rx_last_q <= 1'b0;
                                rx_data_q <= pend_q;
                                pend_q <= bus.data;
                                pend_v_q <= 1'b1;
                            end
                            nxt_q <= rx_ready_i;
                        end
                    end
                    default:
                    begin
                        state_q <= PHY_IDLE;
                    end
                endcase
            end
        end
    end

    // enables all drop together while held in chip reset
    assign bus.ulpi_clock_output = clk_out_q;
    assign bus.ulpi_clock_output_oe = clk_oe_q;
    assign bus.dir = dir_q;
    assign bus.dir_oe = pins_on_q;
    assign bus.nxt = nxt_q;
    assign bus.nxt_oe = pins_on_q;
    assign bus.phy_data = data_q;
    assign bus.phy_data_oe = data_oe_q & pins_on_q;
    assign tx_ready_o = tx_ready_q;
    assign rx_data_o = rx_data_q;
    assign rx_valid_o = rx_valid_q;
    assign rx_last_o = rx_last_q;
    assign suspended_o = suspended_q;
    assign ref_sel_o = ref_sel_q;
    assign clock_in_mode_o = mode_q;
endmodule : ulpisr_phy

// ---- sim/ulpisr_properties.sv ----
`timescale 1ns/10ps
module ulpisr_properties (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic chip_reset_n_i,
    input wire logic ulpi_clock_output,
    input wire logic ulpi_clock_output_oe,
    input wire logic dir,
    input wire logic dir_oe,
    input wire logic nxt,
    input wire logic nxt_oe,
    input wire logic stp,
    input wire logic phy_data_oe,
    input wire logic link_data_oe
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // one ulpi period is three or four system clocks
    a_stp_one_period: assert property (
        $rose(stp) |-> stp [*3] ##[1:2] !stp)
        else $error("stp not high for exactly one period");
    a_bus_single_owner: assert property (
        !(phy_data_oe && link_data_oe))
        else $error("both ends drive the data bus");
    a_data_needs_dir: assert property (
        phy_data_oe |-> dir && dir_oe)
        else $error("device drives data without dir");
    a_link_yields_bus: assert property (
        $rose(dir) |-> ##[1:5] !link_data_oe)
        else $error("link kept the bus after dir rose");
    a_dir_drop_release: assert property (
        $fell(dir) |-> !phy_data_oe)
        else $error("device drives data after dir fell");
    a_nxt_accepts_link: assert property (
        nxt && !dir |-> link_data_oe)
        else $error("nxt without a link byte on the bus");
    // two sync stages plus the pins_on_q/clk_oe_q enable flops
    a_pins_float: assert property (
        !chip_reset_n_i [*4] |-> !dir_oe && !nxt_oe && !phy_data_oe
            && !ulpi_clock_output_oe)
        else $error("pins driven while chip reset held");
    a_clock_narrow: assert property (
        ulpi_clock_output |=> !ulpi_clock_output [*2])
        else $error("ulpi clock pulses too close");
    a_clock_rate: assert property (
        (ulpi_clock_output && ulpi_clock_output_oe && chip_reset_n_i
            && $past(chip_reset_n_i) && $past(chip_reset_n_i, 2))
            ##1 chip_reset_n_i [*3] |-> ##[0:1] ulpi_clock_output)
        else $error("ulpi clock pulse missing");

    c_stop: cover property ($rose(stp));
    c_turnaround: cover property ($rose(dir) ##[1:8] phy_data_oe);
    c_long_reset: cover property (!chip_reset_n_i [*8]);
endmodule : ulpisr_properties

// ---- sim/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic chip_reset_n_i = 1'b1;
    logic mode = 1'b0;
    logic [1:0] ref_sel = 2'h0;
    logic [1:0] old_sel;
    logic [7:0] p_tx_data = 8'h00;
    logic [7:0] l_tx_data = 8'h00;
    logic p_tx_valid = 1'b0;
    logic p_tx_last = 1'b0;
    logic l_tx_valid = 1'b0;
    logic l_tx_last = 1'b0;
    logic rx_ready = 1'b1;
    logic supply = 1'b1;
    logic p_tx_ready, p_rx_valid, p_rx_last, suspended, mode_o;
    logic l_tx_ready, l_rx_valid, l_rx_last, oe_q;
    logic [7:0] p_rx_data, l_rx_data;
    logic [1:0] ref_sel_o;
    logic [8:0] ph_q[$];
    logic [8:0] lk_q[$];
    logic [7:0] wire_q[$];
    int fails = 0;
    int checked = 0;

    ulpisr_if bus_if();

    ulpisr_phy #(.RESET_HOLD_CYC(4)) ulpisr_phy_i (
        .clk_i(clk_i), .reset_n_i(reset_n_i),
        .chip_reset_n_i(chip_reset_n_i), .interface_supply_i(supply),
        .clock_in_mode_i(mode), .ref_sel_i(ref_sel),
        .tx_data_i(p_tx_data), .tx_valid_i(p_tx_valid),
        .tx_last_i(p_tx_last), .tx_ready_o(p_tx_ready),
        .rx_ready_i(rx_ready), .rx_data_o(p_rx_data),
        .rx_valid_o(p_rx_valid), .rx_last_o(p_rx_last),
        .suspended_o(suspended), .ref_sel_o(ref_sel_o),
        .clock_in_mode_o(mode_o), .bus(bus_if.phy)
    );
    ulpisr_link ulpisr_link_i (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .clock_in_mode_i(mode),
        .tx_data_i(l_tx_data), .tx_valid_i(l_tx_valid),
        .tx_last_i(l_tx_last), .tx_ready_o(l_tx_ready),
        .rx_data_o(l_rx_data), .rx_valid_o(l_rx_valid),
        .rx_last_o(l_rx_last), .bus(bus_if.link)
    );
    ulpisr_properties ulpisr_properties_i (
        .clk_i(clk_i), .reset_n_i(reset_n_i),
        .chip_reset_n_i(chip_reset_n_i),
        .ulpi_clock_output(bus_if.ulpi_clock_output),
        .ulpi_clock_output_oe(bus_if.ulpi_clock_output_oe),
        .dir(bus_if.dir), .dir_oe(bus_if.dir_oe), .nxt(bus_if.nxt),
        .nxt_oe(bus_if.nxt_oe), .stp(bus_if.stp),
        .phy_data_oe(bus_if.phy_data_oe), .link_data_oe(bus_if.link_data_oe)
    );

    initial bus_if.osc_clk = 1'b0;
    always #8.3 bus_if.osc_clk = ~bus_if.osc_clk;
    always #2.5 clk_i = ~clk_i;

    // strobes stand one cycle, so every edge is looked at
    always @(posedge clk_i)
    begin
        if (p_rx_valid === 1'b1) ph_q.push_back({p_rx_last, p_rx_data});
        if (l_rx_valid === 1'b1) lk_q.push_back({l_rx_last, l_rx_data});
        if (bus_if.phy_data_oe === 1'b1 && oe_q !== 1'b1)
            wire_q.push_back(bus_if.data);
        oe_q <= bus_if.phy_data_oe;
    end

    function automatic logic [8:0] entry(input logic last,
                                         input logic [7:0] b);
        return {last, b};
    endfunction : entry

    task automatic check(input logic [8:0] got, input logic [8:0] want);
        checked++;
        if (got !== want)
        begin
            fails++;
            $display("MISMATCH t=%0t got %h want %h", $time, got, want);
        end
    endtask : check

    task automatic conclude;
        $display("fails=%0d checked=%0d", fails, checked);
        if (fails == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    task automatic expired;
        fails++;
        $display("MISMATCH t=%0t wait ran out", $time);
        conclude();
    endtask : expired

    task automatic wait_awake;
        int k;
        for (k = 0; k < 100; k++)
        begin
            @(posedge clk_i);
            #1;
            if (suspended === 1'b0) break;
        end
        if (k == 100) expired();
    endtask : wait_awake

    task automatic send(input bit to_phy, input logic [7:0] b,
                        input logic last);
        int k;
        if (to_phy) {l_tx_data, l_tx_valid, l_tx_last} = {b, 1'b1, last};
        else {p_tx_data, p_tx_valid, p_tx_last} = {b, 1'b1, last};
        for (k = 0; k < 200; k++)
        begin
            @(posedge clk_i);
            #1;
            if ((to_phy ? l_tx_ready : p_tx_ready) === 1'b1) break;
        end
        if (k == 200) expired();
        if (last)
        begin
            l_tx_valid = 1'b0;
            p_tx_valid = 1'b0;
        end
    endtask : send

    task automatic frame(input bit to_phy, input int n,
                         input logic [7:0] first);
        logic [8:0] exp[$];
        logic [7:0] b;
        logic [8:0] got;
        int i;
        int k;
        for (i = 0; i < n; i++)
        begin
            b = (i == 0) ? first : 8'($urandom);
            exp.push_back(entry(i == n - 1, b));
            send(to_phy, b, i == n - 1);
        end
        for (k = 0; k < 300; k++)
        begin
            @(posedge clk_i);
            if ((to_phy ? ph_q.size() : lk_q.size()) >= n) break;
        end
        if (k == 300) expired();
        #1;
        for (i = 0; i < n; i++)
        begin
            got = to_phy ? ph_q.pop_front() : lk_q.pop_front();
            check(got, exp[i]);
        end
        if (!to_phy)
            check({1'b0, wire_q.pop_front()}, {1'b0, first});
        repeat (12) @(posedge clk_i);
        #1;
    endtask : frame

    task automatic chip_pulse(input int cyc);
        chip_reset_n_i = 1'b0;
        repeat (cyc) @(posedge clk_i);
        #1;
        if (cyc > 6)
        begin
            check({8'h00, suspended}, 9'h001);
            check({5'h00, bus_if.dir_oe, bus_if.nxt_oe, bus_if.phy_data_oe,
                   bus_if.ulpi_clock_output_oe}, 9'h000);
        end
        chip_reset_n_i = 1'b1;
        wait_awake();
    endtask : chip_pulse

    initial
    begin
        void'($urandom(32'h1945905B));
        repeat (8) @(posedge clk_i);
        #1;
        reset_n_i = 1'b1;
        wait_awake();
        check({6'h00, mode_o, ref_sel_o}, {6'h00, mode, ref_sel});
        // bit-order corners: msb alone, lsb alone, all ones, all zeros
        frame(1'b1, 1, 8'h80);
        frame(1'b0, 1, 8'h01);
        frame(1'b1, 4, 8'hFF);
        frame(1'b0, 4, 8'h00);
        for (int m = 0; m < 2; m++)
        begin
            for (int j = 0; j < 8; j++)
                frame(j[0], 1 + $urandom_range(3),
                      8'($urandom_range(1, 255)));
            // user not ready: link must wait for nxt
            rx_ready = 1'b0;
            fork
                begin
                    repeat (20) @(posedge clk_i);
                    #1;
                    rx_ready = 1'b1;
                end
            join_none
            frame(1'b1, 3, 8'h5A);
            ref_sel = 2'($urandom);
            mode = ~mode;
            chip_pulse(12);
            check({6'h00, mode_o, ref_sel_o},
                  {6'h00, mode, ref_sel});
        end
        // short pulse only suspends, straps stay as latched
        old_sel = ref_sel;
        ref_sel = ~ref_sel;
        chip_pulse(2);
        check({7'h00, ref_sel_o}, {7'h00, old_sel});
        // supply loss floats the pins as well, without a full reset
        supply = 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        check({7'h00, suspended, bus_if.dir_oe}, 9'h002);
        supply = 1'b1;
        wait_awake();
        frame(1'b1, 2, 8'h3C);
        frame(1'b0, 2, 8'hC3);
        conclude();
    end
endmodule : tb_top
